//--- rtl/spp_top.sv
// Standard PCS to core port packing with APB control and interrupt
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module spp_top #(
	parameter int NUM_CH = 2,
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                             ref_clk,
	input  wire logic                             resetn,
	// APB slave
	input  wire logic [ADDR_W-1:0]                paddr,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// Core side parallel buses
	input  wire logic [NUM_CH*spp_pkg::SLICE_W-1:0] txParallelData,
	output logic      [NUM_CH*spp_pkg::SLICE_W-1:0] rxParallelData,
	// PCS side
	output logic      [NUM_CH*spp_pkg::PCS_W-1:0]   txPcsData,
	input  wire logic [NUM_CH*spp_pkg::PCS_W-1:0]   rxPcsData,
	input  wire logic [NUM_CH*2-1:0]                alignerPatternSizeFlag,
	input  wire logic [NUM_CH*2-1:0]                rxSyncStatus,
	input  wire logic [NUM_CH*2-1:0]                rxPatternDetect,
	input  wire logic [NUM_CH*2-1:0]                rxDispErr,
	input  wire logic [NUM_CH*2-1:0]                rxRmFifoStatus0,
	input  wire logic [NUM_CH-1:0]                  rxDataValid,
	// Interrupt
	output logic                                  irq
);
	// ****************************************
	// Register state
	// ****************************************
	logic                          ctrlEn_r;
	logic                          ctrlEn_nxt;
	logic [spp_pkg::MODE_W-1:0]    ctrlMode_r;
	logic [spp_pkg::MODE_W-1:0]    ctrlMode_nxt;
	logic [spp_pkg::EVT_W-1:0]     irqStat_r;
	logic [spp_pkg::EVT_W-1:0]     irqStat_nxt;
	logic [spp_pkg::EVT_W-1:0]     irqMask_r;
	logic [spp_pkg::EVT_W-1:0]     irqMask_nxt;
	logic                          irq_r;
	logic                          irq_nxt;
	logic [31:0]                   prdata_r;
	logic [31:0]                   prdata_nxt;
	logic                          pready_r;
	logic                          pready_nxt;
	logic                          pslverr_r;
	logic                          pslverr_nxt;
	logic [NUM_CH-1:0]             syncPrev_r;
	logic [NUM_CH-1:0]             syncPrev_nxt;
	logic [NUM_CH-1:0]             syncNow;
	logic [spp_pkg::EVT_W-1:0]     evt;
	logic                          setupPhase;
	logic                          wrTake;
	logic [11:0]                   addr;
	spp_pkg::spp_mode_t            mode;

	assign mode       = spp_pkg::spp_mode_t'(ctrlMode_r);
	assign setupPhase = psel && !penable;
	assign wrTake     = psel && penable && pready_r && pwrite;
	assign addr       = 12'(paddr);

	// ****************************************
	// Channel slices
	// ****************************************
	// Each lane sees the same layout; only the slice base moves
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_lane
		spp_lane u_lane (
			.ref_clk                (ref_clk),
			.resetn                 (resetn),
			.enable                 (ctrlEn_r),
			.mode                   (mode),
			.txSlice                (txParallelData[ch*spp_pkg::SLICE_W +: spp_pkg::SLICE_W]),
			.rxSlice_r              (rxParallelData[ch*spp_pkg::SLICE_W +: spp_pkg::SLICE_W]),
			.txData_r               (txPcsData[ch*spp_pkg::PCS_W +: spp_pkg::PCS_W]),
			.rxData                 (rxPcsData[ch*spp_pkg::PCS_W +: spp_pkg::PCS_W]),
			.alignerPatternSizeFlag (alignerPatternSizeFlag[ch*2 +: 2]),
			.syncStatus             (rxSyncStatus[ch*2 +: 2]),
			.patternDetect          (rxPatternDetect[ch*2 +: 2]),
			.dispErr                (rxDispErr[ch*2 +: 2]),
			.rmFifoStatus0          (rxRmFifoStatus0[ch*2 +: 2]),
			.dataValid              (rxDataValid[ch])
		);

		a_slice_offset: assert property (@(posedge ref_clk) disable iff (!resetn)
			($past(ctrlEn_r) && $past(mode) != spp_pkg::SPP_MODE_OFF)
			|-> rxParallelData[ch*spp_pkg::SLICE_W + spp_pkg::VALID_BIT] == $past(rxDataValid[ch]))
			else $error("channel valid bit not at its slice offset");
		a_same_layout: assert property (@(posedge ref_clk) disable iff (!resetn)
			($past(ctrlEn_r) && $past(mode) == spp_pkg::SPP_MODE_10)
			|-> rxParallelData[ch*spp_pkg::SLICE_W +: spp_pkg::SYM_W] == $past(rxPcsData[ch*spp_pkg::PCS_W +: 10]))
			else $error("channel data not at its slice offset");
	end

	// ****************************************
	// Receive events
	// ****************************************
	// Taken from the packed slices, so events follow the active mode
	always_comb begin
		evt          = '0;
		syncNow      = '0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			syncNow[ch] = rxParallelData[ch*spp_pkg::SLICE_W + spp_pkg::SYNC_LO];
			evt[spp_pkg::EVT_DISP] = evt[spp_pkg::EVT_DISP]
				| rxParallelData[ch*spp_pkg::SLICE_W + spp_pkg::DISP_LO];
			evt[spp_pkg::EVT_PAT]  = evt[spp_pkg::EVT_PAT]
				| rxParallelData[ch*spp_pkg::SLICE_W + spp_pkg::PAT_LO];
		end
		evt[spp_pkg::EVT_SYNC_LOST] = |(syncPrev_r & ~syncNow);
		syncPrev_nxt = syncNow;
	end

	// ****************************************
	// APB registers and interrupt
	// ****************************************
	// Decode at setup so read data comes from a flop in the access cycle
	always_comb begin
		ctrlEn_nxt   = ctrlEn_r;
		ctrlMode_nxt = ctrlMode_r;
		irqMask_nxt  = irqMask_r;
		irqStat_nxt  = irqStat_r;
		prdata_nxt   = prdata_r;
		pslverr_nxt  = 1'b0;
		pready_nxt   = setupPhase;
		if (setupPhase) begin
			prdata_nxt = '0;
			if (addr == spp_pkg::OFS_CTRL) begin
				prdata_nxt[spp_pkg::CTRL_EN] = ctrlEn_r;
				prdata_nxt[spp_pkg::CTRL_MODE_LSB +: spp_pkg::MODE_W] = ctrlMode_r;
			end else if (addr == spp_pkg::OFS_IRQ_STAT) begin
				prdata_nxt[spp_pkg::EVT_W-1:0] = irqStat_r;
			end else if (addr == spp_pkg::OFS_IRQ_MASK) begin
				prdata_nxt[spp_pkg::EVT_W-1:0] = irqMask_r;
			end else if (addr == spp_pkg::OFS_LIVE) begin
				prdata_nxt[NUM_CH-1:0] = syncNow;
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
		if (wrTake) begin
			if (addr == spp_pkg::OFS_CTRL) begin
				ctrlEn_nxt   = pwdata[spp_pkg::CTRL_EN];
				ctrlMode_nxt = pwdata[spp_pkg::CTRL_MODE_LSB +: spp_pkg::MODE_W];
			end else if (addr == spp_pkg::OFS_IRQ_STAT) begin
				irqStat_nxt = irqStat_r & ~pwdata[spp_pkg::EVT_W-1:0];
			end else if (addr == spp_pkg::OFS_IRQ_MASK) begin
				irqMask_nxt = pwdata[spp_pkg::EVT_W-1:0];
			end
		end
		// A new event beats a clear written in the same cycle
		irqStat_nxt = irqStat_nxt | evt;
		irq_nxt     = |(irqStat_nxt & irqMask_nxt);
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctrlEn_r   <= spp_pkg::CTRL_EN_RST;
			ctrlMode_r <= spp_pkg::CTRL_MODE_RST;
			irqStat_r  <= spp_pkg::IRQ_STAT_RST;
			irqMask_r  <= spp_pkg::IRQ_MASK_RST;
			irq_r      <= 1'b0;
			prdata_r   <= '0;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			syncPrev_r <= '0;
		end else begin
			ctrlEn_r   <= ctrlEn_nxt;
			ctrlMode_r <= ctrlMode_nxt;
			irqStat_r  <= irqStat_nxt;
			irqMask_r  <= irqMask_nxt;
			irq_r      <= irq_nxt;
			prdata_r   <= prdata_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
			syncPrev_r <= syncPrev_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;

	// ****************************************
	// Bus and interrupt checks
	// ****************************************
	a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		irq == |(irqStat_r & irqMask_r))
		else $error("interrupt does not follow masked status");
	a_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
		(evt != '0) |=> ((irqStat_r & $past(evt)) == $past(evt)))
		else $error("event lost against clear");
	a_w1c_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wrTake && addr == spp_pkg::OFS_IRQ_STAT && evt == '0)
		|=> (irqStat_r & $past(pwdata[2:0])) == '0)
		else $error("status bit not cleared by one");
	a_access_one: assert property (@(posedge ref_clk) disable iff (!resetn)
		setupPhase |=> pready ##1 !pready || (psel && !penable))
		else $error("access phase not one cycle");
	a_mode_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wrTake && addr == spp_pkg::OFS_CTRL) |=> ##1 (ctrlMode_r == $past(pwdata[2:1], 2)))
		else $error("mode write not taken");
endmodule : spp_top
`default_nettype wire

//--- rtl/spp_pkg.sv
// Shared constants and types of the standard PCS core port packing block
package spp_pkg;

	// ****************************************
	// Slice geometry
	// ****************************************
	localparam int SLICE_W  = 80;
	localparam int PCS_W    = 20;
	localparam int BYTE_W   = 8;
	localparam int SYM_W    = 10;
	localparam int FLAG_W   = 2;

	// ****************************************
	// Field positions inside one channel slice
	// ****************************************
	localparam int DATA_LSB     = 0;
	localparam int TX_HI_LSB    = 11;
	localparam int RX_HI_LSB    = 16;
	localparam int PCS_HI_LSB   = 10;
	localparam int ALIGN_LO     = 8;
	localparam int SYNC_LO      = 10;
	localparam int DISP_LO      = 11;
	localparam int PAT_LO       = 12;
	localparam int RMFIFO0_LO   = 13;
	localparam int ALIGN_HI     = 24;
	localparam int SYNC_HI      = 26;
	localparam int PAT_HI       = 28;
	localparam int VALID_BIT    = 79;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h004;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
	localparam logic [11:0] OFS_LIVE     = 12'h00C;

	localparam int          CTRL_EN       = 0;
	localparam int          CTRL_MODE_LSB = 1;
	localparam int          MODE_W        = 2;
	localparam logic        CTRL_EN_RST   = 1'b0;
	localparam logic [1:0]  CTRL_MODE_RST = 2'h0;

	localparam int          EVT_W         = 3;
	localparam int          EVT_SYNC_LOST = 0;
	localparam int          EVT_DISP      = 1;
	localparam int          EVT_PAT       = 2;
	localparam logic [2:0]  IRQ_STAT_RST  = 3'h0;
	localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

	typedef enum logic [1:0] {
		SPP_MODE_8,
		SPP_MODE_8SER,
		SPP_MODE_10,
		SPP_MODE_OFF
	} spp_mode_t;

endpackage : spp_pkg

//--- rtl/spp_lane.sv
// One channel slice: packs receive fields and unpacks transmit data
`timescale 1ns/1ps
`default_nettype none
module spp_lane (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      resetn,
	// Configuration
	input  wire logic                      enable,
	input  wire spp_pkg::spp_mode_t        mode,
	// Core side
	input  wire logic [spp_pkg::SLICE_W-1:0] txSlice,
	output logic      [spp_pkg::SLICE_W-1:0] rxSlice_r,
	// PCS side
	output logic      [spp_pkg::PCS_W-1:0]   txData_r,
	input  wire logic [spp_pkg::PCS_W-1:0]   rxData,
	input  wire logic [1:0]                  alignerPatternSizeFlag,
	input  wire logic [1:0]                  syncStatus,
	input  wire logic [1:0]                  patternDetect,
	input  wire logic [1:0]                  dispErr,
	input  wire logic [1:0]                  rmFifoStatus0,
	input  wire logic                        dataValid
);
	logic [spp_pkg::SLICE_W-1:0] rxSlice_nxt;
	logic [spp_pkg::PCS_W-1:0]   txData_nxt;

	// ****************************************
	// Packing
	// ****************************************
	// Unused slice bits stay zero; unused transmit bits are never looked at
	always_comb begin
		rxSlice_nxt = '0;
		txData_nxt  = '0;
		if (enable) begin
			case (mode)
				spp_pkg::SPP_MODE_8, spp_pkg::SPP_MODE_8SER: begin
					txData_nxt[spp_pkg::DATA_LSB +: spp_pkg::BYTE_W]  = txSlice[spp_pkg::DATA_LSB +: spp_pkg::BYTE_W];
					rxSlice_nxt[spp_pkg::DATA_LSB +: spp_pkg::BYTE_W] = rxData[spp_pkg::DATA_LSB +: spp_pkg::BYTE_W];
					rxSlice_nxt[spp_pkg::ALIGN_LO] = alignerPatternSizeFlag[0];
					rxSlice_nxt[spp_pkg::SYNC_LO]  = syncStatus[0];
					rxSlice_nxt[spp_pkg::PAT_LO]   = patternDetect[0];
					rxSlice_nxt[spp_pkg::VALID_BIT] = dataValid;
					if (mode == spp_pkg::SPP_MODE_8SER) begin
						txData_nxt[spp_pkg::BYTE_W +: spp_pkg::BYTE_W] = txSlice[spp_pkg::TX_HI_LSB +: spp_pkg::BYTE_W];
						rxSlice_nxt[spp_pkg::RX_HI_LSB +: spp_pkg::BYTE_W] =
							rxData[spp_pkg::PCS_HI_LSB +: spp_pkg::BYTE_W];
						rxSlice_nxt[spp_pkg::ALIGN_HI] = alignerPatternSizeFlag[1];
						rxSlice_nxt[spp_pkg::SYNC_HI]  = syncStatus[1];
						rxSlice_nxt[spp_pkg::PAT_HI]   = patternDetect[1];
					end
				end
				spp_pkg::SPP_MODE_10: begin
					txData_nxt[spp_pkg::DATA_LSB +: spp_pkg::SYM_W]  = txSlice[spp_pkg::DATA_LSB +: spp_pkg::SYM_W];
					rxSlice_nxt[spp_pkg::DATA_LSB +: spp_pkg::SYM_W] = rxData[spp_pkg::DATA_LSB +: spp_pkg::SYM_W];
					rxSlice_nxt[spp_pkg::SYNC_LO]    = syncStatus[0];
					rxSlice_nxt[spp_pkg::DISP_LO]    = dispErr[0];
					rxSlice_nxt[spp_pkg::PAT_LO]     = patternDetect[0];
					rxSlice_nxt[spp_pkg::RMFIFO0_LO] = rmFifoStatus0[0];
					rxSlice_nxt[spp_pkg::VALID_BIT]  = dataValid;
				end
				default: begin
					rxSlice_nxt = '0;
				end
			endcase
		end
	end

	// One complete unit per clock, no word alternation
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rxSlice_r <= '0;
			txData_r  <= '0;
		end else begin
			rxSlice_r <= rxSlice_nxt;
			txData_r  <= txData_nxt;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_rx_valid_bit: assert property (@(posedge ref_clk) disable iff (!resetn)
		($past(enable) && $past(mode) != spp_pkg::SPP_MODE_OFF) |-> rxSlice_r[spp_pkg::VALID_BIT] == $past(dataValid))
		else $error("valid bit not at top of slice");
	a_low_byte_map: assert property (@(posedge ref_clk) disable iff (!resetn)
		($past(enable) && $past(mode) == spp_pkg::SPP_MODE_8)
		|-> (txData_r[7:0] == $past(txSlice[7:0]) && rxSlice_r[8] == $past(alignerPatternSizeFlag[0])
		&& rxSlice_r[12] == $past(patternDetect[0]) && rxSlice_r[7:0] == $past(rxData[7:0])))
		else $error("low byte fields misplaced");
	a_high_byte_map: assert property (@(posedge ref_clk) disable iff (!resetn)
		($past(enable) && $past(mode) == spp_pkg::SPP_MODE_8SER)
		|-> (txData_r[15:8] == $past(txSlice[18:11]) && rxSlice_r[23:16] == $past(rxData[17:10])))
		else $error("upper byte misplaced");
	a_high_flag_map: assert property (@(posedge ref_clk) disable iff (!resetn)
		($past(enable) && $past(mode) == spp_pkg::SPP_MODE_8SER)
		|-> (rxSlice_r[24] == $past(alignerPatternSizeFlag[1]) && rxSlice_r[26] == $past(syncStatus[1])
		&& rxSlice_r[28] == $past(patternDetect[1])))
		else $error("upper byte flags misplaced");
	a_ten_bit_map: assert property (@(posedge ref_clk) disable iff (!resetn)
		($past(enable) && $past(mode) == spp_pkg::SPP_MODE_10)
		|-> (rxSlice_r[9:0] == $past(rxData[9:0]) && rxSlice_r[11] == $past(dispErr[0])
		&& rxSlice_r[13] == $past(rmFifoStatus0[0]) && txData_r[9:0] == $past(txSlice[9:0])))
		else $error("ten bit fields misplaced");
	a_unused_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
		($past(enable) && $past(mode) == spp_pkg::SPP_MODE_8)
		|-> (rxSlice_r[78:13] == '0 && rxSlice_r[11] == 1'b0 && rxSlice_r[9] == 1'b0 && txData_r[19:8] == '0))
		else $error("unused slice bits not zero");
endmodule : spp_lane
`default_nettype wire

//--- tb/spp_core_model.sv
// Core-side model: places transmit units into channel slices, junk in unused bits
`timescale 1ns/1ps
`default_nettype none
module spp_core_model #(
	parameter int NUM_CH = 2
) (
	// Clock
	input  wire logic                 ref_clk,
	// Stimulus
	input  wire spp_pkg::spp_mode_t   mode,
	input  wire logic [NUM_CH*20-1:0] txUnit,
	// Core transmit bus
	output logic      [NUM_CH*80-1:0] txParallelData
);
	logic toggleR = 1'b0;
	// Unused bits flip every cycle, so a design that leaks them is seen
	always @(posedge ref_clk) toggleR <= ~toggleR;

	function automatic logic [79:0] place(input spp_pkg::spp_mode_t m, input logic t, input logic [19:0] u);
		logic [79:0] s;
		s = {40{t, ~t}};
		if (m != spp_pkg::SPP_MODE_10) s[7:0] = u[7:0];
		if (m == spp_pkg::SPP_MODE_8SER) s[18:11] = u[15:8];
		if (m == spp_pkg::SPP_MODE_10) s[9:0] = u[9:0];
		return s;
	endfunction : place

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			txParallelData[c*80 +: 80] = place(mode, toggleR, txUnit[c*20 +: 20]);
		end
	end
endmodule : spp_core_model
`default_nettype wire

//--- tb/test_standard_pcs_core_port_packing.sv
// Self-checking bench of the standard PCS core port packing block
`timescale 1ns/1ps
`default_nettype none
module test_standard_pcs_core_port_packing;
	typedef struct {
		spp_pkg::spp_mode_t m;
		logic [19:0]        p;
		logic [1:0]         al, sy, pd, de, rm;
		logic               v;
		logic [19:0]        u;
	} spp_row_t;
	logic               ref_clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata;
	logic [159:0]       txParallelData, rxParallelData;
	logic [39:0]        txPcsData, rxPcsData, txUnit;
	logic [3:0]         alignFlag, rxSync, rxPat, rxDisp, rxRm;
	logic [1:0]         rxValid;
	spp_pkg::spp_mode_t modelMode;
	int                 fails, nChecks;
	spp_row_t rows[7] = '{
		'{spp_pkg::SPP_MODE_8,    20'hA5C3E, 2'h1, 2'h2, 2'h1, 2'h3, 2'h3, 1'b1, 20'h5A3C7},
		'{spp_pkg::SPP_MODE_8,    20'h00000, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 1'b0, 20'hFFFFF},
		'{spp_pkg::SPP_MODE_8SER, 20'hB7E5A, 2'h3, 2'h1, 2'h2, 2'h1, 2'h2, 1'b1, 20'h1C3A5},
		'{spp_pkg::SPP_MODE_8SER, 20'h48125, 2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 1'b0, 20'hE5C3A},
		'{spp_pkg::SPP_MODE_10,   20'h3FF81, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 1'b1, 20'h003FF},
		'{spp_pkg::SPP_MODE_10,   20'hC0155, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 1'b0, 20'hFFC00},
		'{spp_pkg::SPP_MODE_OFF,  20'hFFFFF, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 1'b1, 20'hFFFFF}};

	spp_top #(.NUM_CH(2), .ADDR_W(12)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.txParallelData(txParallelData), .rxParallelData(rxParallelData), .txPcsData(txPcsData),
		.rxPcsData(rxPcsData), .alignerPatternSizeFlag(alignFlag), .rxSyncStatus(rxSync),
		.rxPatternDetect(rxPat), .rxDispErr(rxDisp), .rxRmFifoStatus0(rxRm), .rxDataValid(rxValid), .irq(irq));
	spp_core_model #(.NUM_CH(2)) i_core (.ref_clk(ref_clk), .mode(modelMode), .txUnit(txUnit),
		.txParallelData(txParallelData));

	// ****
	// Checking and bus tasks
	// ****
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chkWord(input logic [79:0] got, input logic [79:0] exp, input string what);
		nChecks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chkWord
	task automatic chkFlag(input logic got, input logic exp, input string what);
		nChecks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chkFlag
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
			output logic err);
		bit got;
		got = 1'b0;
		rd = '0;
		err = 1'b0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Answer is taken at the rising edge where pready is seen high, never earlier
		for (int n = 0; n < 16 && !got; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) begin
				got = 1'b1;
				rd = prdata;
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		chkFlag(got, 1'b1, "apb answer");
		if (!got) finish_test();
		@(posedge ref_clk);
	endtask : apb
	task automatic regWr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask : regWr
	task automatic regChk(input logic [11:0] a, input logic [31:0] exp, input logic expErr, input string what);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		chkWord(80'(rd), 80'(exp), what);
		chkFlag(err, expErr, what);
	endtask : regChk
	task automatic waitIrq;
		bit got;
		got = 1'b0;
		for (int n = 0; n < 8 && !got; n++) begin
			@(negedge ref_clk);
			got = (irq === 1'b1);
			@(posedge ref_clk);
		end
		chkFlag(got, 1'b1, "irq raised");
		if (!got) finish_test();
	endtask : waitIrq
	function automatic spp_row_t flip(input spp_row_t r);
		return '{r.m, ~r.p, ~r.al, ~r.sy, ~r.pd, ~r.de, ~r.rm, ~r.v, ~r.u};
	endfunction : flip
	function automatic logic [79:0] expRx(input spp_row_t r);
		logic [79:0] s;
		s = '0;
		if (r.m == spp_pkg::SPP_MODE_OFF) return s;
		s[79] = r.v;
		if (r.m == spp_pkg::SPP_MODE_10) s[13:0] = {r.rm[0], r.pd[0], r.de[0], r.sy[0], r.p[9:0]};
		else s[12:0] = {r.pd[0], 1'b0, r.sy[0], 1'b0, r.al[0], r.p[7:0]};
		if (r.m == spp_pkg::SPP_MODE_8SER) s[28:16] = {r.pd[1], 1'b0, r.sy[1], 1'b0, r.al[1], r.p[17:10]};
		return s;
	endfunction : expRx
	function automatic logic [79:0] expTx(input spp_row_t r);
		case (r.m)
			spp_pkg::SPP_MODE_8:    return 80'(r.u[7:0]);
			spp_pkg::SPP_MODE_8SER: return 80'(r.u[15:0]);
			spp_pkg::SPP_MODE_10:   return 80'(r.u[9:0]);
			default:                return 80'h0;
		endcase
	endfunction : expTx
	task automatic driveRow(input spp_row_t r);
		rxPcsData <= {~r.p, r.p};
		alignFlag <= {~r.al, r.al};
		rxSync <= {~r.sy, r.sy};
		rxPat <= {~r.pd, r.pd};
		rxDisp <= {~r.de, r.de};
		rxRm <= {~r.rm, r.rm};
		rxValid <= {~r.v, r.v};
		txUnit <= {~r.u, r.u};
		modelMode <= r.m;
	endtask : driveRow
	task automatic checkRow(input spp_row_t r);
		chkWord(rxParallelData[79:0], expRx(r), "rx slice 0");
		chkWord(rxParallelData[159:80], expRx(flip(r)), "rx slice 1");
		chkWord(80'(txPcsData[19:0]), expTx(r), "tx unit 0");
		chkWord(80'(txPcsData[39:20]), expTx(flip(r)), "tx unit 1");
	endtask : checkRow

	// ****
	// Main sequence
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, rxPcsData, txUnit} = '0;
		{alignFlag, rxSync, rxPat, rxDisp, rxRm, rxValid} = '0;
		modelMode = spp_pkg::SPP_MODE_8;
		fails = 0;
		nChecks = 0;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		regChk(spp_pkg::OFS_CTRL, 32'h0, 1'b0, "ctrl reset");
		regChk(spp_pkg::OFS_IRQ_STAT, 32'h0, 1'b0, "status reset");
		regChk(spp_pkg::OFS_IRQ_MASK, 32'h0, 1'b0, "mask reset");
		chkWord(rxParallelData[79:0], 80'h0, "rx after reset");
		$display("test reset done");
		foreach (rows[i]) begin
			regWr(spp_pkg::OFS_CTRL, {29'h0, rows[i].m, 1'b1});
			driveRow(rows[i]);
			@(posedge ref_clk);
			@(negedge ref_clk);
			checkRow(rows[i]);
			@(posedge ref_clk);
		end
		$display("test table done");
		// One full word every clock, alternating contents
		regWr(spp_pkg::OFS_CTRL, {29'h0, spp_pkg::SPP_MODE_8SER, 1'b1});
		for (int k = 0; k < 5; k++) begin
			driveRow(rows[2 + k % 2]);
			@(negedge ref_clk);
			if (k > 0) checkRow(rows[2 + (k - 1) % 2]);
			@(posedge ref_clk);
		end
		$display("test back to back done");
		regWr(spp_pkg::OFS_CTRL, 32'h0);
		driveRow(rows[0]);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chkWord(rxParallelData[79:0], 80'h0, "disabled rx");
		chkWord(80'(txPcsData[19:0]), 80'h0, "disabled tx");
		@(posedge ref_clk);
		regChk(12'h010, 32'h0, 1'b1, "unmapped");
		regWr(spp_pkg::OFS_LIVE, 32'hFFFFFFFF);
		regChk(spp_pkg::OFS_LIVE, 32'h0, 1'b0, "live read only");
		$display("test refusals done");
		regWr(spp_pkg::OFS_CTRL, {29'h0, spp_pkg::SPP_MODE_8, 1'b1});
		{rxSync, rxPat, rxDisp} <= {4'h5, 8'h0};
		repeat (3) @(posedge ref_clk);
		regWr(spp_pkg::OFS_IRQ_STAT, 32'h7);
		regWr(spp_pkg::OFS_IRQ_MASK, 32'h1);
		regChk(spp_pkg::OFS_LIVE, 32'h3, 1'b0, "live sync");
		chkFlag(irq, 1'b0, "irq idle");
		rxSync <= 4'h4;
		waitIrq();
		regChk(spp_pkg::OFS_IRQ_STAT, 32'h1, 1'b0, "sync lost");
		regWr(spp_pkg::OFS_IRQ_STAT, 32'h1);
		@(negedge ref_clk);
		chkFlag(irq, 1'b0, "irq cleared");
		@(posedge ref_clk);
		regWr(spp_pkg::OFS_IRQ_MASK, 32'h0);
		rxPat <= 4'h1;
		@(posedge ref_clk);
		rxPat <= 4'h0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chkFlag(irq, 1'b0, "irq masked");
		@(posedge ref_clk);
		regChk(spp_pkg::OFS_IRQ_STAT, 32'h4, 1'b0, "pattern event");
		regWr(spp_pkg::OFS_CTRL, {29'h0, spp_pkg::SPP_MODE_10, 1'b1});
		repeat (3) @(posedge ref_clk);
		regWr(spp_pkg::OFS_IRQ_STAT, 32'h7);
		regWr(spp_pkg::OFS_IRQ_MASK, 32'h2);
		rxDisp <= 4'h1;
		waitIrq();
		regChk(spp_pkg::OFS_IRQ_STAT, 32'h2, 1'b0, "disparity event");
		// Disparity is still standing, so its event must beat this clear
		regWr(spp_pkg::OFS_IRQ_STAT, 32'h2);
		regChk(spp_pkg::OFS_IRQ_STAT, 32'h2, 1'b0, "set beats clear");
		chkFlag(irq, 1'b1, "irq held by event");
		$display("test interrupt done");
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chkWord(rxParallelData[79:0], 80'h0, "rx in reset");
		chkFlag(irq, 1'b0, "irq in reset");
		@(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		regChk(spp_pkg::OFS_CTRL, 32'h0, 1'b0, "ctrl after reset");
		regChk(spp_pkg::OFS_IRQ_MASK, 32'h0, 1'b0, "mask after reset");
		$display("test second reset done");
		finish_test();
	end
endmodule : test_standard_pcs_core_port_packing
`default_nettype wire
